// >>> hw/ihb_pkg.sv
// Constants for the host IPv4 binding gate: register index, field positions,
// reset value and the bits that software may change.
// Assumes a 16-bit PHY register port with six-bit register indices.
package ihb_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int REG_AW = 6;
    localparam int REG_DW = 16;
    localparam logic [5:0] HBC_LO_IDX = 6'h2A;
    localparam logic [5:0] HBC_HI_IDX = 6'h2B;
    localparam logic [31:0] HBC_RESET = 32'h0000_0000;
    // Bits 11 and 13 are reserved and stay zero.
    localparam logic [31:0] HBC_WR_MASK = 32'hFFFF_D7FF;

    // ------------------------------------------------------------------
    // Field positions of the filters that can be bound
    // ------------------------------------------------------------------
    localparam int NUM_FILT = 32;
    localparam int TCP_LSB = 0;
    localparam int TCP_MSB = 10;
    localparam int UDP0_BIT = 12;
    localparam int EAP_BIT = 14;
    localparam int DNS_BIT = 15;
    localparam int FLEX_LSB = 16;
    localparam int FLEX_MSB = 27;
    localparam int RANGE_BIT = 28;
    localparam int ICMP_BIT = 29;
    localparam int ARP_BIT = 30;
    localparam int RMCP_BIT = 31;

endpackage

// >>> hw/ihb_bind_if.sv
// Carries the live binding vector from the register file to the gate.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface ihb_bind_if;
    logic [31:0] bind_vec;

    modport src (
        output bind_vec
    );
    modport snk (
        input bind_vec
    );
endinterface

// >>> hw/ihb_gate.sv
// Per-filter gate: a filter hit passes unless its binding bit is set and
// the packet misses the host IPv4 address filters.
// Assumes filter hits and the address match arrive together with pkt_valid.
`timescale 1ns/10ps
module ihb_gate #(
    parameter int NF = ihb_pkg::NUM_FILT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Binding vector
    ihb_bind_if.snk bnd,
    // Packet decision inputs
    input wire logic pkt_valid,
    input wire logic [NF-1:0] filt_hit,
    input wire logic host_ipv4_hit,
    // Gated decision
    output logic [NF-1:0] pass_ff,
    output logic valid_ff
);

    // ------------------------------------------------------------------
    // Gate terms
    // ------------------------------------------------------------------
    wire [NF-1:0] nxt_pass;

    genvar g;
    generate
        for (g = 0; g < NF; g++) begin : g_bit
            // A clear bit leaves the filter to decide alone.
            assign nxt_pass[g] = pkt_valid & filt_hit[g] &
                (~bnd.bind_vec[g] | host_ipv4_hit);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Decision register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pass_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            pass_ff <= nxt_pass;
            valid_ff <= pkt_valid;
        end
    end

endmodule

// >>> hw/ihb_top.sv
// Host IPv4 binding gate: binding control register on the PHY register
// port and the gate that applies it to each receive filter decision.
// Assumes one 250 MHz clock; all inputs come from logic on that clock.
//
// Functional notes
// - Bits 0-10 bind TCP port filters 0-10 to a host IPv4 match.
// - Bit 12 binds the UDP port 0 filter to a host IPv4 match.
// - Bit 14 binds the EAP over UDP filter to a host IPv4 match.
// - Bit 15 binds the DNS filter to a host IPv4 match.
// - Bits 16-27 bind flexible port filters 0-11 in order.
// - Bit 28 binds the port-range filter to a host IPv4 match.
// - Bit 29 binds the ICMPv4 filter to a host IPv4 match.
// - Bit 30 binds ARP request and response filtering likewise.
// - Bit 31 binds the RMCP filter to a host IPv4 match.
`timescale 1ns/10ps
module ihb_top #(
    parameter int NF = ihb_pkg::NUM_FILT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // PHY register port
    input wire logic [ihb_pkg::REG_AW-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ihb_pkg::REG_DW-1:0] reg_wdata,
    output logic [ihb_pkg::REG_DW-1:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    // Receive filter decisions in
    input wire logic pkt_valid,
    input wire logic [NF-1:0] filt_hit,
    input wire logic host_ipv4_hit,
    // Gated decisions out
    output logic [NF-1:0] gate_pass,
    output logic gate_valid,
    output logic host_route
);

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    logic [31:0] hbc_ff;
    wire sel_lo = (reg_addr == ihb_pkg::HBC_LO_IDX);
    wire sel_hi = (reg_addr == ihb_pkg::HBC_HI_IDX);
    wire wr_lo = reg_wr_en & sel_lo;
    wire wr_hi = reg_wr_en & sel_hi;

    // Reserved positions keep their stored zero whatever is written.
    wire [31:0] wr_word = {reg_wdata, reg_wdata};
    wire [31:0] wr_bits = {{16{wr_hi}}, {16{wr_lo}}} & ihb_pkg::HBC_WR_MASK;
    wire [31:0] nxt_hbc = (hbc_ff & ~wr_bits) | (wr_word & wr_bits);

    // Unmapped indices read as zero.
    wire [15:0] nxt_rdata = sel_lo ? hbc_ff[15:0] :
                            sel_hi ? hbc_ff[31:16] : 16'h0000;

    // ------------------------------------------------------------------
    // Binding control register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hbc_ff <= ihb_pkg::HBC_RESET;
        end else begin
            hbc_ff <= nxt_hbc;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_ff <= 16'h0000;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Binding vector, one field group at a time
    // ------------------------------------------------------------------
    ihb_bind_if bnd ();

    wire [10:0] bind_tcp =
        hbc_ff[ihb_pkg::TCP_MSB:ihb_pkg::TCP_LSB];
    wire bind_udp_port_filter_zero = hbc_ff[ihb_pkg::UDP0_BIT];
    wire bind_eap_over_udp_filter = hbc_ff[ihb_pkg::EAP_BIT];
    wire bind_name_service_filter = hbc_ff[ihb_pkg::DNS_BIT];
    wire [11:0] bind_flex =
        hbc_ff[ihb_pkg::FLEX_MSB:ihb_pkg::FLEX_LSB];
    wire bind_port_range_filter = hbc_ff[ihb_pkg::RANGE_BIT];
    wire bind_icmp = hbc_ff[ihb_pkg::ICMP_BIT];
    wire bind_arp = hbc_ff[ihb_pkg::ARP_BIT];
    wire bind_rmcp = hbc_ff[ihb_pkg::RMCP_BIT];

    assign bnd.bind_vec = {bind_rmcp, bind_arp, bind_icmp,
                           bind_port_range_filter, bind_flex,
                           bind_name_service_filter, bind_eap_over_udp_filter,
                           1'b0, bind_udp_port_filter_zero, 1'b0, bind_tcp};

    // ------------------------------------------------------------------
    // Gate
    // ------------------------------------------------------------------
    logic [NF-1:0] pass_q;
    logic valid_q;

    ihb_gate #(
        .NF(NF)
    ) u_gate (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .bnd(bnd.snk),
        .pkt_valid(pkt_valid),
        .filt_hit(filt_hit),
        .host_ipv4_hit(host_ipv4_hit),
        .pass_ff(pass_q),
        .valid_ff(valid_q)
    );

    assign gate_pass = pass_q;
    assign gate_valid = valid_q;
    // The packet goes to the host when any gated filter still passes.
    assign host_route = valid_q & (|pass_q);

endmodule

// >>> tb/ihb_assertions.sv
// Concurrent checks on the ports of the host IPv4 binding gate.
// Assumes one clock and the one-cycle latencies of ihb_top.
`timescale 1ns/10ps
module ihb_chk #(
    parameter int NF = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata_ff,
    input wire logic reg_rvalid_ff,
    // Packet path
    input wire logic pkt_valid,
    input wire logic [NF-1:0] filt_hit,
    input wire logic host_ipv4_hit,
    input wire logic [NF-1:0] gate_pass,
    input wire logic gate_valid,
    input wire logic host_route
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_valid_delay: assert property ($past(nrst) |->
        gate_valid == $past(pkt_valid)) else $error("gate_valid latency");
    a_pass_idle: assert property (!gate_valid |-> gate_pass == '0)
        else $error("pass without packet");
    a_pass_subset: assert property (gate_valid |->
        (gate_pass & ~$past(filt_hit)) == '0) else $error("pass without hit");
    a_host_match: assert property (gate_valid &&
        $past(host_ipv4_hit) |-> gate_pass == $past(filt_hit))
        else $error("matched packet blocked");
    a_resv_thru: assert property (gate_valid |->
        {gate_pass[13], gate_pass[11]} == $past({filt_hit[13], filt_hit[11]}))
        else $error("reserved position gated");
    a_route_or: assert property (host_route == (gate_valid && |gate_pass))
        else $error("host_route mismatch");
    a_rd_pulse: assert property ($past(nrst) |->
        reg_rvalid_ff == $past(reg_rd_en)) else $error("read latency");
    a_resv_read: assert property (reg_rvalid_ff &&
        $past(reg_addr) == 6'h2A |->
        {reg_rdata_ff[13], reg_rdata_ff[11]} == 2'b00)
        else $error("reserved bit reads one");
    a_unmap_zero: assert property (reg_rvalid_ff &&
        !($past(reg_addr) inside {6'h2A, 6'h2B}) |-> reg_rdata_ff == '0)
        else $error("unmapped read not zero");
endmodule
bind ihb_top ihb_chk #(.NF(NF)) u_chk (.*);

// >>> tb/tb.sv
// Self-checking bench for ihb_top: register port and packet gating.
// Assumes one-cycle read and decision latencies.
`timescale 1ns/10ps
module tb;
    logic ref_clk = 0;
    logic nrst = 0;
    logic [5:0] reg_addr = '0;
    logic reg_wr_en = 0, reg_rd_en = 0, pkt_valid = 0, host_ipv4_hit = 0;
    logic [15:0] reg_wdata = '0, reg_rdata_ff, e_rd;
    logic [31:0] filt_hit = '0, gate_pass, shadow = '0, e, b;
    logic reg_rvalid_ff, gate_valid, host_route;
    logic [31:0] q_pkt[$];
    logic [15:0] q_rd[$];
    int err_total = 0, checks_done = 0;
    always #2 ref_clk = ~ref_clk;
    ihb_top dut (.ref_clk, .nrst, .reg_addr, .reg_wr_en, .reg_rd_en,
        .reg_wdata, .reg_rdata_ff, .reg_rvalid_ff, .pkt_valid, .filt_hit,
        .host_ipv4_hit, .gate_pass, .gate_valid, .host_route);
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One cycle of stimulus; expectations use the value before any write.
    task automatic cyc(logic wr, logic rd, logic [5:0] a, logic [15:0] d,
                       logic pv, logic [31:0] h, logic ip);
        @(posedge ref_clk);
        #1;
        {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {wr, rd, a, d};
        {pkt_valid, filt_hit, host_ipv4_hit} = {pv, h, ip};
        if (pv) q_pkt.push_back(h & (~shadow | {32{ip}}));
        if (rd) q_rd.push_back(a == 6'h2A ? shadow[15:0] :
                               a == 6'h2B ? shadow[31:16] : 16'h0000);
        if (wr && a == 6'h2A) shadow[15:0] = d & 16'hD7FF;
        if (wr && a == 6'h2B) shadow[31:16] = d;
    endtask
    always @(negedge ref_clk) begin
        if (gate_valid === 1'b1) begin
            e = q_pkt.size() ? q_pkt.pop_front() : 'x;
            chk("lo", gate_pass[15:0], e[15:0]);
            chk("hi", gate_pass >> 16, e >> 16);
            chk("route", host_route, |e);
        end
        if (reg_rvalid_ff === 1'b1) begin
            e_rd = q_rd.size() ? q_rd.pop_front() : 'x;
            chk("rdata", reg_rdata_ff, e_rd);
        end
    end
    initial begin
        void'($urandom(8));
        repeat (2) @(posedge ref_clk);
        #1 nrst = 1;
        cyc(0, 1, 6'h2A, 0, 0, 0, 0);
        cyc(1, 1, 6'h2B, 16'hFFFF, 0, 0, 0);
        // Bind one position at a time and offer every filter hit, except random hits on the high-half write.
        for (int i = 0; i < 32; i++) begin
            b = 32'h1 << i;
            cyc(1, 0, 6'h2A, b[15:0], 1, '1, 0);
            cyc(1, 1, 6'h2B, b[31:16], 1, $urandom, 0);
            cyc(0, 1, 6'h2A, 0, 1, '1, 0);
            cyc(0, 1, 6'h2B, 0, 1, '1, 1);
        end
        repeat (300) begin
            cyc(1'($urandom), 1'($urandom), 6'h28 + 6'($urandom % 4),
                16'($urandom), 1'($urandom), $urandom, 1'($urandom));
        end
        cyc(0, 0, 0, 0, 0, 0, 0);
        repeat (3) @(posedge ref_clk);
        chk("pending", q_pkt.size() + q_rd.size(), 0);
        // A reset in mid-run must return both halves to zero.
        #1 nrst = 0;
        shadow = '0;
        repeat (2) @(posedge ref_clk);
        #1 nrst = 1;
        cyc(0, 1, 6'h2A, 0, 1, '1, 0);
        cyc(0, 1, 6'h2B, 0, 1, $urandom, 0);
        cyc(0, 0, 0, 0, 0, 0, 0);
        repeat (3) @(posedge ref_clk);
        chk("pending", q_pkt.size() + q_rd.size(), 0);
        stop_test();
    end
    initial begin
        #4000;
        err_total++;
        stop_test();
    end
endmodule
